/* dwi_host.sv */
// master end: takes a frame over axi4-lite and sends it on the link
// assumes the link carries one wiper slave; no clock stretching
module dwi_host #(
  parameter int QTR = dwi_pkg::QTR_CYC
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  dwi_link_if.host link // two-wire link
);
  import dwi_pkg::*;

  localparam logic [15:0] QTR_LAST = 16'(QTR - 1);

  typedef struct packed {
    dwi_host_state_t st;
    logic [1:0] ph;
    logic [15:0] div;
    logic [4:0] idx;
    logic [4:0] last;
    logic [26:0] frame;
    logic scl_low;
    logic sda_low;
    logic nack;
    logic [23:0] frame_reg;
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dwi_host_regs_t;

  dwi_host_regs_t r_q;
  dwi_host_regs_t r_d;
  logic sda_s;
  logic tick;
  logic go;
  logic [31:0] merged;

  dwi_sync #(.W(1), .RST_VAL(1'b1)) dwi_sync_i (
    .clk(clk),
    .reset(reset),
    .d(link.sda),
    .q(sda_s)
  );

  // channels stay closed while an answer is pending
  assign s_axi_awready = !r_q.aw_got && !r_q.bvalid;
  assign s_axi_wready = !r_q.w_got && !r_q.bvalid;
  assign s_axi_arready = !r_q.rvalid;
  assign tick = (r_q.div == QTR_LAST);
  assign merged = dwi_merge({8'h00, r_q.frame_reg}, r_q.wdata, r_q.wstrb);

  always_comb
  begin
    r_d = r_q;
    go = 1'b0;
    // bus slave: address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_d.aw_got = 1'b1;
      r_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_d.w_got = 1'b1;
      r_d.wdata = s_axi_wdata;
      r_d.wstrb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready)
    begin
      r_d.bvalid = 1'b0;
    end
    if (r_q.aw_got && r_q.w_got)
    begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = RESP_SLVERR;
      // a frame write while busy is refused so the wire never glitches
      if (r_q.awaddr == REG_FRAME && r_q.st == H_IDLE)
      begin
        r_d.bresp = RESP_OKAY;
        r_d.frame_reg = merged[23:0];
        go = 1'b1;
      end
      else if (r_q.awaddr == REG_STATUS)
      begin
        r_d.bresp = RESP_OKAY;
      end
    end
    // read side
    if (r_q.rvalid && s_axi_rready)
    begin
      r_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rresp = RESP_OKAY;
      r_d.rdata = 32'h00000000;
      if (s_axi_araddr == REG_FRAME)
      begin
        r_d.rdata = {8'h00, r_q.frame_reg};
      end
      else if (s_axi_araddr == REG_STATUS)
      begin
        r_d.rdata[ST_BUSY_BIT] = (r_q.st != H_IDLE);
        r_d.rdata[ST_NACK_BIT] = r_q.nack;
      end
      else
      begin
        r_d.rresp = RESP_SLVERR;
      end
    end
    // link engine, four quarters per bit
    if (go)
    begin
      r_d.st = H_START;
      r_d.ph = 2'h0;
      r_d.div = 16'h0000;
      r_d.nack = 1'b0;
      // released slots after each byte leave room for the ack
      r_d.frame = {merged[FRM_ADDR_LSB +: 7], merged[FRM_NOP_BIT], 1'b1,
                   merged[FRM_CMD_LSB +: 8], 1'b1,
                   merged[FRM_DATA_LSB +: 8], 1'b1};
      r_d.idx = FRAME_TOP;
      // a no-op ends after the address byte
      r_d.last = merged[FRM_NOP_BIT] ? ACK_ADDR_IDX : ACK_DATA_IDX;
    end
    else if (r_q.st != H_IDLE)
    begin
      r_d.div = tick ? 16'h0000 : r_q.div + 16'h0001;
      if (tick)
      begin
        r_d.ph = r_q.ph + 2'h1;
        unique case (r_q.st)
          H_START:
          begin
            if (r_q.ph == 2'h0)
            begin
              r_d.sda_low = 1'b1;
            end
            else
            begin
              r_d.scl_low = 1'b1;
              r_d.st = H_BIT;
              r_d.ph = 2'h0;
            end
          end
          H_BIT:
          begin
            // data moves only while the clock is low
            if (r_q.ph == 2'h0)
            begin
              r_d.sda_low = !r_q.frame[r_q.idx];
            end
            else if (r_q.ph == 2'h1)
            begin
              r_d.scl_low = 1'b0;
            end
            else if (r_q.ph == 2'h3)
            begin
              r_d.scl_low = 1'b1;
              r_d.idx = r_q.idx - 5'h01;
              if (r_q.idx == ACK_ADDR_IDX || r_q.idx == ACK_CMD_IDX ||
                  r_q.idx == ACK_DATA_IDX)
              begin
                if (sda_s || r_q.idx == r_q.last)
                begin
                  r_d.nack = sda_s;
                  r_d.st = H_STOP;
                end
              end
            end
          end
          H_STOP:
          begin
            if (r_q.ph == 2'h0)
            begin
              r_d.sda_low = 1'b1;
            end
            else if (r_q.ph == 2'h1)
            begin
              r_d.scl_low = 1'b0;
            end
            else if (r_q.ph == 2'h2)
            begin
              r_d.sda_low = 1'b0;
            end
            else
            begin
              r_d.st = H_IDLE;
            end
          end
          H_IDLE:
          begin
            r_d.st = H_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_q <= '{st: H_IDLE, frame_reg: FRAME_RESET, bresp: RESP_OKAY,
               rresp: RESP_OKAY, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  // open drain: only ever pull low
  assign link.scl_o = 1'b0;
  assign link.scl_oe = r_q.scl_low;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = r_q.sda_low;
endmodule

/* dwi_pkg.sv */
// shared constants and types for the dual wiper two-wire link
// assumes a 100 MHz system clock at both ends
package dwi_pkg;
  // fixed upper address nibble of the slave
  localparam logic [3:0] DEV_ADDR_HI = 4'h5;
  // command codes
  localparam logic [7:0] CMD_WIPER_A = 8'h11;
  localparam logic [7:0] CMD_WIPER_B = 8'h12;
  localparam logic [7:0] CMD_WIPER_AB = 8'h13;
  // wiper power-on value, mid-scale
  localparam logic [7:0] WIPER_RESET = 8'h80;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // serial clock timing for the master end
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYC = SYS_CLK_HZ / (4 * SCL_HZ);
  // frame: address byte, command byte, data byte, nine slots each
  localparam logic [4:0] FRAME_TOP = 5'h1A;
  localparam logic [4:0] ACK_ADDR_IDX = 5'h12;
  localparam logic [4:0] ACK_CMD_IDX = 5'h09;
  localparam logic [4:0] ACK_DATA_IDX = 5'h00;
  // host register map, byte offsets
  localparam logic [3:0] REG_FRAME = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // frame register fields
  localparam int FRM_DATA_LSB = 0;
  localparam int FRM_CMD_LSB = 8;
  localparam int FRM_ADDR_LSB = 16;
  localparam int FRM_NOP_BIT = 23;
  localparam logic [23:0] FRAME_RESET = 24'h000000;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ADDR = 2'b01,
    DEV_CMD = 2'b10,
    DEV_DATA = 2'b11
  } dwi_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } dwi_host_state_t;

  // byte-lane merge of a bus write into an old word
  function automatic logic [31:0] dwi_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

/* dwi_link_if.sv */
// the two-wire link between master and wiper slave
// assumes pull-ups: a line is low only while some end pulls it low
interface dwi_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and of the open-drain drivers
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

  modport host (output scl_o, scl_oe, m_sda_o, m_sda_oe, input sda);
  modport device (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

/* dwi_sync.sv */
// two flip-flop synchroniser for inputs from outside the clock domain
// assumes nothing but the system clock; resets to the idle level
module dwi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dwi_sync_t;

  dwi_sync_t r_q;
  dwi_sync_t r_d;

  // first stage feeds only the second stage
  always_comb
  begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_q <= '{s1: RST_VAL, s2: RST_VAL};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule

/* dwi_device.sv */
// slave end: receives write frames and holds two wiper positions
// assumes the master owns the serial clock and keeps data stable
// while that clock is high; straps are static board levels
//
// What this block does
// - master changes data only while clock low
// - each byte is eight bits plus ack
// - receiver pulls data low on ninth pulse
// - eighth address bit: zero write, one no-op
// - no read path; wipers never read back
// - address is 0101 plus three strap inputs
// - each device on bus needs distinct straps
// - write frame: address, command byte, data byte
// - data byte goes where command byte points
// - command 11h loads wiper a position
// - command 12h loads wiper b position
// - command 13h loads both wiper positions
// - written position takes effect at once
// - start and stop framed while clock high
module dwi_device (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  dwi_link_if.device link, // two-wire link
  input wire logic addr_select_0, // strap, address bit 0
  input wire logic addr_select_1, // strap, address bit 1
  input wire logic addr_select_2, // strap, address bit 2
  output logic [7:0] wiper_a_position, // wiper a tap, 00h near low end
  output logic [7:0] wiper_b_position // wiper b tap, 00h near low end
);
  import dwi_pkg::*;

  typedef struct packed {
    dwi_dev_state_t st;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic ack_phase;
    logic drive;
    logic [7:0] cmd;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] wa;
    logic [7:0] wb;
  } dwi_dev_regs_t;

  // power-on state: idle lines, both wipers at mid-scale
  localparam dwi_dev_regs_t DEV_RST = '{
    st: DEV_IDLE,
    shift: 8'h00,
    cnt: 4'h0,
    ack_phase: 1'b0,
    drive: 1'b0,
    cmd: 8'h00,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    wa: WIPER_RESET,
    wb: WIPER_RESET
  };

  dwi_dev_regs_t r_q;
  dwi_dev_regs_t r_d;
  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] strap_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_hit;
  logic hit_a;
  logic hit_b;

  // link lines and straps all come from outside the clock domain
  dwi_sync #(.W(5), .RST_VAL(5'h1F)) dwi_sync_i (
    .clk(clk),
    .reset(reset),
    .d({link.scl, link.sda, addr_select_2, addr_select_1,
        addr_select_0}),
    .q(pins_s)
  );

  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign strap_s = pins_s[2:0];

  // edge and condition detection on the synchronised copies
  assign scl_rise = scl_s && !r_q.scl_prev;
  assign scl_fall = !scl_s && r_q.scl_prev;
  // data edges with the clock high in both samples frame a transfer
  assign start_seen = scl_s && r_q.scl_prev && r_q.sda_prev &&
                      !sda_s;
  assign stop_seen = scl_s && r_q.scl_prev && !r_q.sda_prev &&
                     sda_s;

  // strap order is select 2, 1, 0 from the msb down
  assign addr_hit = (r_q.shift[7:1] == {DEV_ADDR_HI, strap_s});

  // command decode; any other code selects neither wiper
  assign hit_a = (r_q.cmd == CMD_WIPER_A) ||
                 (r_q.cmd == CMD_WIPER_AB);
  assign hit_b = (r_q.cmd == CMD_WIPER_B) ||
                 (r_q.cmd == CMD_WIPER_AB);

  // receive engine; start and stop override any bit in flight
  always_comb
  begin
    r_d = r_q;
    r_d.scl_prev = scl_s;
    r_d.sda_prev = sda_s;
    if (start_seen)
    begin
      // a repeated start also restarts address matching
      r_d.st = DEV_ADDR;
      r_d.cnt = 4'h0;
      r_d.ack_phase = 1'b0;
      r_d.drive = 1'b0;
    end
    else if (stop_seen)
    begin
      // a half-received byte is simply dropped here
      r_d.st = DEV_IDLE;
      r_d.cnt = 4'h0;
      r_d.ack_phase = 1'b0;
      r_d.drive = 1'b0;
    end
    else if (scl_fall && r_q.ack_phase)
    begin
      // the ninth pulse is over: let go of the data line
      r_d.ack_phase = 1'b0;
      r_d.drive = 1'b0;
      r_d.cnt = 4'h0;
    end
    else if (scl_rise && !r_q.ack_phase && r_q.st != DEV_IDLE)
    begin
      // sample on the rising edge, where the data is stable
      r_d.shift = {r_q.shift[6:0], sda_s};
      r_d.cnt = r_q.cnt + 4'h1;
    end
    else if (scl_fall && r_q.cnt == BYTE_BITS && r_q.st != DEV_IDLE)
    begin
      // eighth bit done; the ack slot follows
      r_d.ack_phase = 1'b1;
      unique case (r_q.st)
        DEV_ADDR:
        begin
          if (addr_hit)
          begin
            // pull low before the ninth clock rises
            r_d.drive = 1'b1;
            // a no-op is acknowledged but nothing follows
            r_d.st = r_q.shift[0] ? DEV_IDLE : DEV_CMD;
          end
          else
          begin
            // another device's address: stay off the bus
            r_d.st = DEV_IDLE;
          end
        end
        DEV_CMD:
        begin
          r_d.cmd = r_q.shift;
          r_d.drive = 1'b1;
          r_d.st = DEV_DATA;
        end
        DEV_DATA:
        begin
          // each further data byte goes to the same wipers
          r_d.drive = 1'b1;
          if (hit_a)
          begin
            r_d.wa = r_q.shift;
          end
          if (hit_b)
          begin
            r_d.wb = r_q.shift;
          end
        end
        DEV_IDLE:
        begin
          r_d.st = DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_q <= DEV_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // the data line is only ever pulled low, never driven high,
  // so there is no way to put register contents on the bus
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = r_q.drive;

  // no shadow latch: the registers are the wiper positions
  assign wiper_a_position = r_q.wa;
  assign wiper_b_position = r_q.wb;
endmodule

/* dwi_link_properties.sv */
// concurrent checks on the two-wire link between master and wiper slave
// assumes every enable is registered in the clk domain; lines resolved
module dwi_link_properties #(
  parameter int QTR = dwi_pkg::QTR_CYC
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic scl_oe, // master pulls scl low
  input wire logic m_sda_oe, // master pulls sda low
  input wire logic s_sda_oe, // slave pulls sda low
  input wire logic scl, // resolved clock line
  input wire logic sda // resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QW = 2 * QTR;
  localparam int BIT = 4 * QTR;
  logic scl_q;
  logic sda_q;
  logic in_frame_q;
  logic [5:0] rises_q;
  logic start_seen;
  logic stop_seen;

  // data edges while the clock stays high mark start and stop
  assign start_seen = scl && scl_q && sda_q && !sda;
  assign stop_seen = scl && scl_q && !sda_q && sda;

  // clock rises since the last start; the stop's release counts too
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame_q <= 1'b0;
      rises_q <= 6'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_seen)
        in_frame_q <= 1'b1;
      else if (stop_seen)
        in_frame_q <= 1'b0;
      if (start_seen)
        rises_q <= 6'h00;
      else if (scl && !scl_q)
        rises_q <= rises_q + 6'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  rst_idle_a: assert property (
    $fell(reset) |-> !scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("link not idle after reset");
  start_bound_a: assert property (start_seen |-> ##[1:QW] !scl)
    else $error("clock not pulled low after start");
  stop_still_a: assert property (stop_seen |=> !scl_oe [*4])
    else $error("clock moved right after stop");
  clock_framed_a: assert property (!in_frame_q |-> !scl_oe)
    else $error("clock pulled outside a frame");
  // the slave may only claim the line in the low phase before a ninth pulse
  ack_slot_a: assert property (
    $rose(s_sda_oe) |-> !scl &&
      (rises_q == 6'h08 || rises_q == 6'h11 || rises_q == 6'h1A))
    else $error("slave ack outside a ninth slot");
  ack_hold_a: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave data moved while clock high");
  ack_reach_a: assert property (
    $rose(s_sda_oe) |-> ##[1:BIT] (scl && s_sda_oe))
    else $error("ack not held into the clock pulse");
  master_free_a: assert property (
    scl && scl_q &&
      (rises_q == 6'h09 || rises_q == 6'h12 || rises_q == 6'h1B) |->
      !m_sda_oe)
    else $error("master drives data in ack slot");
  frame_len_a: assert property (
    stop_seen |-> rises_q == 6'h0A || rises_q == 6'h13 ||
      rises_q == 6'h1C)
    else $error("stop after a partial byte");

  cover property (stop_seen && rises_q == 6'h1C);
  cover property (stop_seen && rises_q == 6'h0A);
  cover property ($rose(s_sda_oe) && rises_q == 6'h1A);
endmodule

/* tb_dual_wiper_i2c_slave.sv */
// self-checking bench: an axi4-lite master feeds the link master end,
// which talks to the wiper slave; the wire itself is watched too
// assumes a 100 MHz clock and a shortened serial bit of 4 * QTR cycles
module tb_dual_wiper_i2c_slave;
  timeunit 1ns;
  timeprecision 1ps;
  import dwi_pkg::*;
  localparam int QTR = 5;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [2:0] straps = 3'h5;
  logic [7:0] wa;
  logic [7:0] wb;
  logic [7:0] exp_a = WIPER_RESET;
  logic [7:0] exp_b = WIPER_RESET;
  logic [26:0] wire_bits = 27'h0;
  logic last_bit = 1'b1;
  logic armed = 1'b0;
  int wire_cnt = 0;
  int cycles = 0;
  int miscompares = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  dwi_link_if dwi_link_if_i ();
  dwi_host #(.QTR(QTR)) dwi_host_i (.clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(dwi_link_if_i));
  dwi_device dwi_device_i (.clk(clk), .reset(reset), .link(dwi_link_if_i),
    .addr_select_0(straps[0]), .addr_select_1(straps[1]),
    .addr_select_2(straps[2]), .wiper_a_position(wa),
    .wiper_b_position(wb));
  dwi_link_properties #(.QTR(QTR)) dwi_link_properties_i (.clk(clk),
    .reset(reset), .scl_oe(dwi_link_if_i.scl_oe),
    .m_sda_oe(dwi_link_if_i.m_sda_oe), .s_sda_oe(dwi_link_if_i.s_sda_oe),
    .scl(dwi_link_if_i.scl), .sda(dwi_link_if_i.sda));

  // wire monitor: a bit counts only once its clock pulse has ended, so the
  // stop's release of the clock adds nothing
  always @(negedge dwi_link_if_i.sda)
  begin
    if (dwi_link_if_i.scl)
    begin
      wire_cnt = 0;
      armed = 1'b0;
    end
  end
  always @(posedge dwi_link_if_i.scl)
  begin
    last_bit = dwi_link_if_i.sda;
    armed = 1'b1;
  end
  always @(negedge dwi_link_if_i.scl)
  begin
    if (armed)
    begin
      wire_bits = {wire_bits[25:0], last_bit};
      wire_cnt = wire_cnt + 1;
    end
  end

  // hang guard, far above the few thousand cycles the frames need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ready is looked at on the falling edge, where it has settled, and the
  // transfer then happens at the rising edge that follows
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    logic got;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge clk);
      if (awready && !aw_done)
        aw_done = 1'b1;
      if (wready && !w_done)
        w_done = 1'b1;
      @(posedge clk);
      if (aw_done)
        awvalid <= 1'b0;
      if (w_done)
        wvalid <= 1'b0;
    end
    while (!got)
    begin
      @(negedge clk);
      got = bvalid;
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge clk);
      done = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      done = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [31:0] st;
    logic [1:0] r;
    int n;
    st = 32'h00000001;
    n = 0;
    while (st[ST_BUSY_BIT] !== 1'b0 && n < 400)
    begin
      axi_read(REG_STATUS, st, r);
      n++;
    end
    check("busy", 32'(st[ST_BUSY_BIT]), 32'h0);
  endtask

  // one frame through the host, then the wire and the status are judged
  task automatic run_frame(input logic [6:0] addr, input logic nop,
                           input logic [7:0] cmd, input logic [7:0] data,
                           input logic ack_ok);
    logic [31:0] st;
    logic [1:0] r;
    axi_write(REG_FRAME, {8'h00, nop, addr, cmd, data}, r);
    check("frame bresp", 32'(r), 32'(RESP_OKAY));
    wait_idle();
    axi_read(REG_STATUS, st, r);
    check("nack flag", 32'(st[ST_NACK_BIT]), 32'(!ack_ok));
    if (ack_ok && !nop)
    begin
      check("wire count", 32'(wire_cnt), 32'h1B);
      check("wire bits", 32'(wire_bits),
            32'({addr, 2'h0, cmd, 1'b0, data, 1'b0}));
    end
    else
    begin
      check("wire count", 32'(wire_cnt), 32'h9);
      check("wire bits", 32'(wire_bits[8:0]),
            32'({addr, nop, !ack_ok}));
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check("wiper a", 32'(wa), 32'(WIPER_RESET));
    check("wiper b", 32'(wb), 32'(WIPER_RESET));
    axi_read(REG_STATUS, d, r);
    check("status", d, 32'h00000000);
    check("status rresp", 32'(r), 32'(RESP_OKAY));
  endtask

  // every command code, plus one that is undefined
  task automatic t_commands();
    logic [7:0] cmds [4] = '{CMD_WIPER_A, CMD_WIPER_B, CMD_WIPER_AB, 8'h14};
    logic [7:0] vals [4] = '{8'hFF, 8'h00, 8'h5A, 8'hC3};
    for (int i = 0; i < 4; i++)
    begin
      run_frame({DEV_ADDR_HI, 3'h5}, 1'b0, cmds[i], vals[i], 1'b1);
      if (cmds[i] == CMD_WIPER_A || cmds[i] == CMD_WIPER_AB)
        exp_a = vals[i];
      if (cmds[i] == CMD_WIPER_B || cmds[i] == CMD_WIPER_AB)
        exp_b = vals[i];
      check("wiper a", 32'(wa), 32'(exp_a));
      check("wiper b", 32'(wb), 32'(exp_b));
    end
  endtask

  // no-op bit set, then new straps and the old address no longer answers
  task automatic t_noop_and_straps();
    run_frame({DEV_ADDR_HI, 3'h5}, 1'b1, CMD_WIPER_A, 8'h01, 1'b1);
    check("wiper a", 32'(wa), 32'(exp_a));
    straps <= 3'h2;
    repeat (4) @(posedge clk);
    run_frame({DEV_ADDR_HI, 3'h2}, 1'b0, CMD_WIPER_B, 8'h33, 1'b1);
    exp_b = 8'h33;
    check("wiper b", 32'(wb), 32'(exp_b));
    run_frame({DEV_ADDR_HI, 3'h5}, 1'b0, CMD_WIPER_A, 8'h77, 1'b0);
    check("wiper a", 32'(wa), 32'(exp_a));
  endtask

  // a second frame while busy, an unmapped read and a status write
  task automatic t_bus_edges();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(REG_FRAME, {9'h000, DEV_ADDR_HI, 3'h2, CMD_WIPER_AB, 8'h9C}, r);
    axi_write(REG_FRAME, {9'h000, DEV_ADDR_HI, 3'h2, CMD_WIPER_A, 8'h11}, r);
    check("busy bresp", 32'(r), 32'(RESP_SLVERR));
    axi_read(4'h8, d, r);
    check("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
    check("unmapped rdata", d, 32'h00000000);
    axi_write(REG_STATUS, 32'hFFFFFFFF, r);
    check("status bresp", 32'(r), 32'(RESP_OKAY));
    wait_idle();
    check("wiper a", 32'(wa), 32'h9C);
    check("wiper b", 32'(wb), 32'h9C);
  endtask

  // only the data lane is written: address and command stay from before,
  // and the readback shows that the other lanes were left alone
  task automatic t_byte_lane();
    logic [31:0] d;
    logic [1:0] r;
    wstrb <= 4'h1;
    axi_write(REG_FRAME, 32'hFFFFFF3C, r);
    wstrb <= 4'hF;
    check("lane bresp", 32'(r), 32'(RESP_OKAY));
    wait_idle();
    axi_read(REG_FRAME, d, r);
    check("frame rresp", 32'(r), 32'(RESP_OKAY));
    check("frame reg", d,
          {9'h000, DEV_ADDR_HI, 3'h2, CMD_WIPER_AB, 8'h3C});
    check("wiper a", 32'(wa), 32'h3C);
    check("wiper b", 32'(wb), 32'h3C);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_commands();
    t_noop_and_straps();
    t_bus_edges();
    t_byte_lane();
    tally_and_finish();
  end
endmodule
